// *** verilog/tcr_pkg.sv ***
// tcr_pkg: constants and types shared by the timer control and auto-reload block
`default_nettype none
package tcr_pkg;
    // ------------------------------------------------------------
    // timer control register
    // ------------------------------------------------------------
    localparam logic [7:0] TCR_TIMER_CONTROL_ADDR  = 8'h88;
    localparam logic [7:0] TCR_TIMER_CONTROL_RESET = 8'h00;
    localparam int TCR_BIT_T1_FLAG  = 7;
    localparam int TCR_BIT_T1_RUN   = 6;
    localparam int TCR_BIT_T0_FLAG  = 5;
    localparam int TCR_BIT_T0_RUN   = 4;
    localparam int TCR_BIT_X1_FLAG  = 3;
    localparam int TCR_BIT_X1_EDGE  = 2;
    localparam int TCR_BIT_X0_FLAG  = 1;
    localparam int TCR_BIT_X0_EDGE  = 0;

    // ------------------------------------------------------------
    // timer 2 auto-reload
    // ------------------------------------------------------------
    localparam logic [15:0] TCR_T2_MAX_COUNT = 16'hFFFF;
    localparam logic [15:0] TCR_T2_COUNT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // uart baud load: divide = 16 * (256 - load), baud_doubler and
    // timer1_sysclk_select set by software
    // ------------------------------------------------------------
    localparam int TCR_BAUD_DIVIDE_EXAMPLE = 208;
    localparam logic [7:0] TCR_BAUD_LOAD_EXAMPLE = 8'hF3;

    typedef struct packed {
        logic run;
        logic capture_reload_select;
        logic clock_select;
        logic external_enable;
    } tcr_t2_cfg_s;

    typedef struct packed {
        logic ext_irq1;
        logic ext_irq0;
        logic timer1;
        logic timer0;
    } tcr_vector_ack_s;

    function automatic logic [7:0] tcr_baud_load(input logic [15:0] divide);
        logic [15:0] q;
        q = divide >> 4;
        return 8'(16'h0100 - q);
    endfunction
endpackage
`default_nettype wire

// *** verilog/tcr_timer_control.sv ***
// tcr_timer_control: timer control register, external interrupt flags, timer 2 auto-reload
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Timer 1 overflow sets its flag; software clears it; vectoring clears it.
// - Timer 0 overflow sets its flag; software clears it; vectoring clears it.
// - Timer 1 run bit high enables Timer 1 counting, low disables it.
// - Timer 0 run bit high enables Timer 0 counting, low disables it.
// - External interrupt 1 flag set on edge or level chosen by select bit.
// - Edge mode: interrupt 1 flag cleared by software or by vectoring.
// - Level mode: interrupt 1 flag follows inverse of its input, not latched.
// - Interrupt 1 select: 1 falling edge, 0 active-low level.
// - Interrupt 0 flag set on chosen edge or level; edge mode clears likewise.
// - Level mode: interrupt 0 flag tracks inverse of its input.
// - Timer 2 sets its overflow flag when a tick finds it at FFFF; it then loads the reload value.
// - Timer 2 flag set and interrupt enabled requests an interrupt.
// - On overflow Timer 2 loads the 16-bit reload value and keeps counting.
// - Timer 2 runs auto-reload when capture/reload select is 0.
// - Writing 1 to Timer 2 run bit starts Timer 2 counting.
// - Timer 2 clock select picks system clock or external pin falling edges.
// - External enable 1: trigger falling edge also reloads Timer 2.
// - External enable 0: trigger input transitions are ignored.
module tcr_timer_control
    import tcr_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire logic [7:0]             sfr_addr,
    input  wire logic                   sfr_wr,
    input  wire logic [7:0]             sfr_wdata,
    input  wire logic                   sfr_rd,
    output logic      [7:0]             sfr_rdata,
    input  wire logic                   timer0_overflow,
    input  wire logic                   timer1_overflow,
    input  wire tcr_vector_ack_s        vector_ack,
    input  wire logic                   ext_irq0_n,
    input  wire logic                   ext_irq1_n,
    input  wire tcr_t2_cfg_s            timer2_cfg,
    input  wire logic [7:0]             timer2_reload_high,
    input  wire logic [7:0]             timer2_reload_low,
    input  wire logic                   timer2_count_pin,
    input  wire logic                   timer2_external_trigger,
    input  wire logic                   timer2_flag_clear,
    input  wire logic                   timer2_irq_enable,
    output logic                        timer0_run,
    output logic                        timer1_run,
    output logic                        ext_irq0_flag,
    output logic                        ext_irq1_flag,
    output logic                        timer0_overflow_flag,
    output logic                        timer1_overflow_flag,
    output logic [COUNT_WIDTH-1:0]      timer2_count,
    output logic                        timer2_overflow_flag,
    output logic                        timer2_irq
);
    // a width the reload path cannot serve is refused at elaboration
    if (COUNT_WIDTH != 16) begin : g_width_check
        $error("timer 2 reload path is exactly 16 bits wide");
    end

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // write and read ports share one address decode
    function automatic logic ctrl_hit(
        input logic [7:0] addr
    );
        return addr == TCR_TIMER_CONTROL_ADDR;
    endfunction

    // high in the last sample and low in this one is a falling edge
    function automatic logic fell_edge(
        input logic prev,
        input logic now
    );
        return prev && !now;
    endfunction

    // edge-mode flag: hardware set beats vector clear beats software write
    function automatic logic edge_flag_next(
        input logic cur,
        input logic set,
        input logic ack,
        input logic wr,
        input logic wbit
    );
        logic nxt;
        nxt = cur;
        if (set) begin
            nxt = 1'b1;
        end else if (ack) begin
            nxt = 1'b0;
        end else if (wr) begin
            nxt = wbit;
        end
        return nxt;
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic       t1_flag_q;
    logic       t1_run_q;
    logic       t0_flag_q;
    logic       t0_run_q;
    logic       x1_flag_q;
    logic       x1_edge_q;
    logic       x0_flag_q;
    logic       x0_edge_q;
    logic [7:0] rdata_q;
    logic       wr_ctrl;
    logic [7:0] ctrl_view;

    // only this one address decodes here; every other address belongs elsewhere
    assign wr_ctrl = sfr_wr && ctrl_hit(sfr_addr);
    assign ctrl_view = {t1_flag_q, t1_run_q, t0_flag_q, t0_run_q,
                        x1_flag_q, x1_edge_q, x0_flag_q, x0_edge_q};

    // ------------------------------------------------------------
    // pin history for edge detection
    // ------------------------------------------------------------
    logic x0_prev_q;
    logic x1_prev_q;
    logic t2_pin_prev_q;
    logic t2_trig_prev_q;
    logic x0_fall;
    logic x1_fall;
    logic t2_pin_fall;
    logic t2_trig_fall;

    // pins are taken as synchronous, so one sample of history is enough
    // pins idle high, so history resets high to avoid a false edge
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            x0_prev_q      <= 1'b1;
            x1_prev_q      <= 1'b1;
            t2_pin_prev_q  <= 1'b1;
            t2_trig_prev_q <= 1'b1;
        end else begin
            x0_prev_q      <= ext_irq0_n;
            x1_prev_q      <= ext_irq1_n;
            t2_pin_prev_q  <= timer2_count_pin;
            t2_trig_prev_q <= timer2_external_trigger;
        end
    end

    assign x0_fall      = fell_edge(x0_prev_q, ext_irq0_n);
    assign x1_fall      = fell_edge(x1_prev_q, ext_irq1_n);
    assign t2_pin_fall  = fell_edge(t2_pin_prev_q, timer2_count_pin);
    assign t2_trig_fall = fell_edge(t2_trig_prev_q, timer2_external_trigger);

    // ------------------------------------------------------------
    // run and type-select bits
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            t1_run_q  <= TCR_TIMER_CONTROL_RESET[TCR_BIT_T1_RUN];
            t0_run_q  <= TCR_TIMER_CONTROL_RESET[TCR_BIT_T0_RUN];
            x1_edge_q <= TCR_TIMER_CONTROL_RESET[TCR_BIT_X1_EDGE];
            x0_edge_q <= TCR_TIMER_CONTROL_RESET[TCR_BIT_X0_EDGE];
        end else if (wr_ctrl) begin
            t1_run_q  <= sfr_wdata[TCR_BIT_T1_RUN];
            t0_run_q  <= sfr_wdata[TCR_BIT_T0_RUN];
            x1_edge_q <= sfr_wdata[TCR_BIT_X1_EDGE];
            x0_edge_q <= sfr_wdata[TCR_BIT_X0_EDGE];
        end
    end

    // ------------------------------------------------------------
    // timer overflow flags: hardware set wins over any clear
    // ------------------------------------------------------------
    // the timer 0 and 1 counters sit outside; only their overflow pulses arrive
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            t1_flag_q <= TCR_TIMER_CONTROL_RESET[TCR_BIT_T1_FLAG];
        end else begin
            t1_flag_q <= edge_flag_next(t1_flag_q, timer1_overflow, vector_ack.timer1,
                                        wr_ctrl, sfr_wdata[TCR_BIT_T1_FLAG]);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            t0_flag_q <= TCR_TIMER_CONTROL_RESET[TCR_BIT_T0_FLAG];
        end else begin
            t0_flag_q <= edge_flag_next(t0_flag_q, timer0_overflow, vector_ack.timer0,
                                        wr_ctrl, sfr_wdata[TCR_BIT_T0_FLAG]);
        end
    end

    // ------------------------------------------------------------
    // external interrupt flags
    // ------------------------------------------------------------
    // level mode ignores software writes: the flag mirrors the pin
    // level flags run one cycle behind their pin
    // a pin held low across a switch to edge mode sets nothing until it rises
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            x1_flag_q <= TCR_TIMER_CONTROL_RESET[TCR_BIT_X1_FLAG];
        end else if (!x1_edge_q) begin
            x1_flag_q <= !ext_irq1_n;
        end else begin
            x1_flag_q <= edge_flag_next(x1_flag_q, x1_fall, vector_ack.ext_irq1,
                                        wr_ctrl, sfr_wdata[TCR_BIT_X1_FLAG]);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            x0_flag_q <= TCR_TIMER_CONTROL_RESET[TCR_BIT_X0_FLAG];
        end else if (!x0_edge_q) begin
            x0_flag_q <= !ext_irq0_n;
        end else begin
            x0_flag_q <= edge_flag_next(x0_flag_q, x0_fall, vector_ack.ext_irq0,
                                        wr_ctrl, sfr_wdata[TCR_BIT_X0_FLAG]);
        end
    end

    // ------------------------------------------------------------
    // register read port, one cycle after the strobe
    // ------------------------------------------------------------
    // zero between reads keeps a stale value off the shared read bus
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (sfr_rd && ctrl_hit(sfr_addr)) begin
            rdata_q <= ctrl_view;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // timer 2, 16-bit auto-reload
    // ------------------------------------------------------------
    logic [15:0] t2_count_q;
    logic        t2_flag_q;
    logic        t2_irq_q;
    logic        t2_active;
    logic        t2_tick;
    logic        t2_wrap;
    logic        t2_ext_reload;
    logic [15:0] t2_reload;

    // capture mode is not built here: with it selected nothing counts or reloads
    assign t2_active = timer2_cfg.run && !timer2_cfg.capture_reload_select;
    assign t2_tick = t2_active &&
                     (timer2_cfg.clock_select ? t2_pin_fall : 1'b1);
    assign t2_wrap = t2_tick && (t2_count_q == TCR_T2_MAX_COUNT);
    assign t2_ext_reload = !timer2_cfg.capture_reload_select &&
                           timer2_cfg.external_enable && t2_trig_fall;
    assign t2_reload = {timer2_reload_high, timer2_reload_low};

    // a trigger reload and a tick together: the reload wins, the tick is lost
    // the trigger reload ignores the run bit, so a stopped timer can be preset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            t2_count_q <= TCR_T2_COUNT_RESET;
        end else if (t2_wrap || t2_ext_reload) begin
            t2_count_q <= t2_reload;
        end else if (t2_tick) begin
            t2_count_q <= t2_count_q + 16'h0001;
        end
    end

    // an overflow beats a clear that lands in the same cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            t2_flag_q <= 1'b0;
        end else if (t2_wrap) begin
            t2_flag_q <= 1'b1;
        end else if (timer2_flag_clear) begin
            t2_flag_q <= 1'b0;
        end
    end

    // the request trails the flag by one cycle so it leaves from a flip-flop
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            t2_irq_q <= 1'b0;
        end else begin
            t2_irq_q <= t2_flag_q && timer2_irq_enable;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output is a flip-flop; nothing is decoded on the way out
    assign sfr_rdata            = rdata_q;
    assign timer0_run           = t0_run_q;
    assign timer1_run           = t1_run_q;
    assign ext_irq0_flag        = x0_flag_q;
    assign ext_irq1_flag        = x1_flag_q;
    assign timer0_overflow_flag = t0_flag_q;
    assign timer1_overflow_flag = t1_flag_q;
    assign timer2_count         = t2_count_q;
    assign timer2_overflow_flag = t2_flag_q;
    assign timer2_irq           = t2_irq_q;
endmodule
`default_nettype wire

// *** bench/tcr_pin_model.sv ***
// pin model: external interrupt, timer 2 count and trigger pins
`timescale 1ns/1ps
`default_nettype none
module tcr_pin_model (
    input  wire logic [3:0] hold_low,
    input  wire logic [3:0] pulse_low,
    output logic            ext_irq0_n,
    output logic            ext_irq1_n,
    output logic            count_pin,
    output logic            trigger
);
    // pull-ups keep released pins high; a pulse is one clock period low
    assign {trigger, count_pin, ext_irq1_n, ext_irq0_n} = ~(hold_low | pulse_low);
endmodule
`default_nettype wire

// *** bench/tcr_chk.sv ***
// assertions on the timer control and timer 2 ports
`timescale 1ns/1ps
`default_nettype none
module tcr_chk
    import tcr_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic                   sys_clk,
    input wire logic                   sys_rst,
    input wire logic [7:0]             sfr_addr,
    input wire logic                   sfr_wr,
    input wire logic [7:0]             sfr_wdata,
    input wire logic                   timer0_overflow,
    input wire logic                   timer1_overflow,
    input wire tcr_vector_ack_s        vector_ack,
    input wire logic                   ext_irq0_n,
    input wire logic                   ext_irq1_n,
    input wire tcr_t2_cfg_s            timer2_cfg,
    input wire logic [7:0]             timer2_reload_high,
    input wire logic [7:0]             timer2_reload_low,
    input wire logic                   timer2_external_trigger,
    input wire logic                   timer2_irq_enable,
    input wire logic                   ext_irq0_flag,
    input wire logic                   ext_irq1_flag,
    input wire logic                   timer0_overflow_flag,
    input wire logic                   timer1_overflow_flag,
    input wire logic [COUNT_WIDTH-1:0] timer2_count,
    input wire logic                   timer2_overflow_flag,
    input wire logic                   timer2_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic      sel1_q;
    logic      sel0_q;
    wire       wr_tc = sfr_wr && sfr_addr == TCR_TIMER_CONTROL_ADDR;
    wire       t2_on = timer2_cfg.run && !timer2_cfg.capture_reload_select;
    wire [15:0] rld  = {timer2_reload_high, timer2_reload_low};
    // shadow of the edge-select bits, which are not visible as ports
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) {sel1_q, sel0_q} <= 2'h0;
        else if (wr_tc) {sel1_q, sel0_q} <= {sfr_wdata[2], sfr_wdata[0]};
    end
    sequence s_tick; t2_on && !timer2_cfg.clock_select; endsequence
    sequence s_trig;
        t2_on && timer2_cfg.external_enable && $fell(timer2_external_trigger);
    endsequence
    a_t2_wrap_reload: assert property (s_tick ##0 timer2_count == 16'hFFFF |=>
        timer2_count == $past(rld) && timer2_overflow_flag) else $error("t2 wrap wrong");
    a_t2_count_up: assert property (s_tick ##0 (timer2_count != 16'hFFFF &&
        !timer2_cfg.external_enable) |=> timer2_count == $past(timer2_count) + 1'b1)
        else $error("t2 count step wrong");
    a_t2_trig_reload: assert property (s_trig |=> timer2_count == $past(rld))
        else $error("t2 trigger reload missing");
    a_t2_stop_hold: assert property (!timer2_cfg.run && !timer2_cfg.external_enable
        |=> $stable(timer2_count)) else $error("t2 moved while stopped");
    a_t2_irq_req: assert property (timer2_overflow_flag && timer2_irq_enable |=> timer2_irq)
        else $error("t2 irq missing");
    a_t0_flag_set: assert property (timer0_overflow |=> timer0_overflow_flag)
        else $error("timer0 flag not set");
    a_t1_ack_clear: assert property (vector_ack.timer1 && !timer1_overflow
        |=> !timer1_overflow_flag) else $error("timer1 flag not cleared");
    a_x1_edge_set: assert property (sel1_q && !wr_tc && $fell(ext_irq1_n)
        |=> ext_irq1_flag) else $error("irq1 edge missed");
    a_x1_level_track: assert property (!sel1_q && !wr_tc
        |=> ext_irq1_flag == !$past(ext_irq1_n)) else $error("irq1 level wrong");
    a_x0_level_track: assert property (!sel0_q && !wr_tc
        |=> ext_irq0_flag == !$past(ext_irq0_n)) else $error("irq0 level wrong");
endmodule
bind tcr_timer_control tcr_chk #(.COUNT_WIDTH(COUNT_WIDTH)) chk_u (.sys_clk, .sys_rst,
    .sfr_addr, .sfr_wr, .sfr_wdata, .timer0_overflow, .timer1_overflow, .vector_ack,
    .ext_irq0_n, .ext_irq1_n, .timer2_cfg, .timer2_reload_high, .timer2_reload_low,
    .timer2_external_trigger, .timer2_irq_enable, .ext_irq0_flag, .ext_irq1_flag,
    .timer0_overflow_flag, .timer1_overflow_flag, .timer2_count, .timer2_overflow_flag,
    .timer2_irq);
`default_nettype wire

// *** bench/test_tcr_timer_control.sv ***
// self-checking bench for the timer control and timer 2 block
`timescale 1ns/1ps
`default_nettype none
module test_tcr_timer_control;
    import tcr_pkg::*;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rhi = 8'h00, rlo = 8'h00, rnd = 8'h56;
    logic        wr = 1'b0, rd = 1'b0, t2en = 1'b0;
    logic [10:0] pls = 11'h000;
    logic [3:0]  hold = 4'h0;
    tcr_t2_cfg_s cfg = 4'h0;
    logic [7:0]  rdata;
    logic        t0run, t1run, x0f, x1f, t0f, t1f, t2f, t2irq, x0n, x1n, cpin, trg;
    logic [15:0] cnt, c;
    int          error_cnt = 0, checked = 0;

    always #4 sys_clk = ~sys_clk;

    tcr_pin_model pin_u (.hold_low(hold), .pulse_low(pls[3:0]), .ext_irq0_n(x0n),
        .ext_irq1_n(x1n), .count_pin(cpin), .trigger(trg));
    tcr_timer_control dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_addr(addr),
        .sfr_wr(wr), .sfr_wdata(wdata), .sfr_rd(rd), .sfr_rdata(rdata),
        .timer0_overflow(pls[4]), .timer1_overflow(pls[5]), .vector_ack(pls[9:6]),
        .ext_irq0_n(x0n), .ext_irq1_n(x1n), .timer2_cfg(cfg), .timer2_reload_high(rhi),
        .timer2_reload_low(rlo), .timer2_count_pin(cpin), .timer2_external_trigger(trg),
        .timer2_flag_clear(pls[10]), .timer2_irq_enable(t2en), .timer0_run(t0run),
        .timer1_run(t1run), .ext_irq0_flag(x0f), .ext_irq1_flag(x1f),
        .timer0_overflow_flag(t0f), .timer1_overflow_flag(t1f), .timer2_count(cnt),
        .timer2_overflow_flag(t2f), .timer2_irq(t2irq));

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // every strobe is held for exactly one rising edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge sys_clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        {addr, rd} = {a, 1'b1};
        @(negedge sys_clk);
        rd = 1'b0;
        cmp(16'(rdata), 16'(exp));
    endtask
    task automatic pulse(input logic [10:0] m);
        @(negedge sys_clk);
        pls = m;
        @(negedge sys_clk);
        pls = 11'h000;
    endtask

    initial begin
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'b0;
        rd_reg(TCR_TIMER_CONTROL_ADDR, TCR_TIMER_CONTROL_RESET);
        cmp(16'(256 - TCR_BAUD_DIVIDE_EXAMPLE / 16), 16'(TCR_BAUD_LOAD_EXAMPLE));
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            wr_reg(8'h88, rnd & 8'h55);
            cmp(16'({t1run, t0run}), 16'({rnd[6], rnd[4]}));
            rd_reg(8'h88, rnd & 8'h55);
        end
        // unmapped address: write dropped, read gives zero
        wr_reg(8'h89, 8'hFF);
        rd_reg(8'h89, 8'h00);
        rd_reg(8'h88, rnd & 8'h55);
        wr_reg(8'h88, 8'h05);
        pulse(11'h030);
        cmp(16'({t1f, t0f}), 16'h3);
        pulse(11'h080);
        cmp(16'({t1f, t0f}), 16'h1);
        // overflow and vector clear in one cycle: the set wins
        pulse(11'h0A0);
        cmp(16'({t1f, t0f}), 16'h3);
        pulse(11'h040);
        cmp(16'({t1f, t0f}), 16'h2);
        wr_reg(8'h88, 8'h05);
        cmp(16'({t1f, t0f}), 16'h0);
        pulse(11'h002);
        cmp(16'({x1f, x0f}), 16'h2);
        rd_reg(8'h88, 8'h0D);
        pulse(11'h200);
        cmp(16'(x1f), 16'h0);
        pulse(11'h001);
        cmp(16'(x0f), 16'h1);
        pulse(11'h100);
        cmp(16'(x0f), 16'h0);
        pulse(11'h001);
        cmp(16'(x0f), 16'h1);
        wr_reg(8'h88, 8'h05);
        cmp(16'(x0f), 16'h0);
        wr_reg(8'h88, 8'h00);
        hold = 4'h3;
        @(negedge sys_clk);
        cmp(16'({x1f, x0f}), 16'h3);
        hold = 4'h0;
        @(negedge sys_clk);
        cmp(16'({x1f, x0f}), 16'h0);
        rnd = lfsr(rnd);
        {rhi, rlo, t2en} = {8'hFF, 2'b10, rnd[5:0], 1'b1};
        cfg = 4'b1001;
        pulse(11'h008);
        cmp(cnt, {rhi, rlo});
        for (int i = 0; i < 200 && t2f !== 1'b1; i++)
            @(negedge sys_clk);
        if (t2f !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
        cmp(cnt, {rhi, rlo});
        @(negedge sys_clk);
        cmp(16'(t2irq), 16'h1);
        pulse(11'h400);
        cmp(16'(t2f), 16'h0);
        cfg = 4'b1000;
        c = cnt;
        pulse(11'h008);
        cmp(cnt, c + 16'h2);
        // count pin as clock: no pin edge, no count
        cfg = 4'b1010;
        c = cnt;
        repeat (3) @(negedge sys_clk);
        cmp(cnt, c);
        pulse(11'h004);
        cmp(cnt, c + 16'h1);
        // capture mode selected: no count and no trigger reload
        cfg = 4'b1101;
        c = cnt;
        pulse(11'h008);
        cmp(cnt, c);
        give_verdict();
    end
endmodule
`default_nettype wire
